//--- mmp_checker.sv
// page-based access checker in front of the core memories
// Notes on behaviour
// R01 - local addresses decode only for own core; global aliases reach all
// R02 - global access to another core memory served unless page denies it
// R03 - global accesses checked against the requestor identifier
// R04 - dma carries programming core identifier; masters present their own
// R05 - a per-page setting allows or blocks local address accesses
// R06 - level-1 program and data memory each have 16 pages of 2k
// R07 - level-2 memory has 64 pages of 32k
// R08 - each page has its own permissions; access checked against its page
// R09 - supervisor and user levels; supervisor gets wider access
// R10 - only supervisor may touch protection configuration
// R11 - every request carries a privilege level used in the decision
// R12 - read, write and execute separately enabled
// R13 - a denied access raises an exception to the core; code raises it only while localCtrl bit 0 is set
// R14 - configuration region writes gated by identifier and privilege
// R15 - denied writes discarded; denied reads return no valid data
// R16 - page holds requestor mask plus user and supervisor r/w/x enables
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
module mmp_checker
  import mmp_pkg::*;
#(
  parameter int CFG_ID_MASK = 16'h0007
)
(
  input wire logic clock,
  input wire logic reset,
  input mmp_pkg::mmp_req_t req,
  output mmp_pkg::mmp_grant_t grant,
  output logic denyValid,
  output logic exception,
  input wire logic [11:0] avmAddress,
  input wire logic avmRead,
  input wire logic avmWrite,
  input wire logic [31:0] avmWriteData,
  input wire logic [3:0] avmByteEnable,
  input wire logic [ID_W-1:0] avmReqId,
  input wire logic avmSupervisor,
  output logic [31:0] avmReadData,
  output logic avmWaitRequest
);
  import mmp_pkg::*;

  // ---------------------------------------------------------------
  // permission tables
  // ---------------------------------------------------------------
  logic [31:0] l1pPerm [L1_PAGES];
  logic [31:0] l1dPerm [L1_PAGES];
  logic [31:0] l2Perm [L2_PAGES];
  logic [31:0] localCtrl;
  logic [31:0] faultAddr;
  logic [31:0] faultInfo;
  logic avmDone;
  logic [31:0] next_readData;

  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // decide one access against a permission word
  function automatic logic perm_ok(input logic [31:0] p,
                                   input mmp_kind_t k,
                                   input logic sup,
                                   input logic [ID_W-1:0] id,
                                   input logic isLocal);
    logic kindOk;
    logic idOk;
    kindOk = 1'b0;
    case (k)
      MMP_READ: kindOk = sup ? p[PERM_SR] : p[PERM_UR]; // R09 R12
      MMP_WRITE: kindOk = sup ? p[PERM_SW] : p[PERM_UW]; // R09 R12
      MMP_FETCH: kindOk = sup ? p[PERM_SX] : p[PERM_UX]; // R09 R12
      default: kindOk = 1'b0;
    endcase
    idOk = isLocal ? p[PERM_LOCAL] : p[PERM_ID_LSB + 32'(id)]; // R03 R05
    return kindOk && idOk; // R16
  endfunction

  // ---------------------------------------------------------------
  // register bus: one wait cycle per access
  // ---------------------------------------------------------------
  logic avmReq;
  logic cfgAllowed;
  assign avmReq = avmRead || avmWrite;
  assign avmWaitRequest = avmReq && !avmDone;
  assign cfgAllowed = avmSupervisor && CFG_ID_MASK[avmReqId]; // R10 R14

  always_ff @(posedge clock)
  begin
    if (reset || avmDone)
    begin
      avmDone <= 1'b0;
    end
    else if (avmReq)
    begin
      avmDone <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      for (int i = 0; i < L1_PAGES; i++)
      begin
        l1pPerm[i] <= PERM_RESET;
        l1dPerm[i] <= PERM_RESET;
      end
      for (int i = 0; i < L2_PAGES; i++)
      begin
        l2Perm[i] <= PERM_RESET;
      end
      localCtrl <= LOCAL_CTRL_RESET;
    end
    else if (avmWrite && avmDone && cfgAllowed) // R14
    begin
      if (avmAddress < CFG_L1D_BASE)
      begin
        l1pPerm[avmAddress[5:2]] <=
          merge_be(l1pPerm[avmAddress[5:2]], avmWriteData, avmByteEnable);
      end
      else if (avmAddress < CFG_L2_BASE)
      begin
        l1dPerm[avmAddress[5:2]] <=
          merge_be(l1dPerm[avmAddress[5:2]], avmWriteData, avmByteEnable);
      end
      else if (avmAddress < CFG_LOCAL_CTRL)
      begin
        l2Perm[6'(avmAddress[11:2] - 10'(CFG_L2_BASE >> 2))] <=
          merge_be(l2Perm[6'(avmAddress[11:2] - 10'(CFG_L2_BASE >> 2))],
                   avmWriteData, avmByteEnable);
      end
      else if (avmAddress == CFG_LOCAL_CTRL)
      begin
        localCtrl <= merge_be(localCtrl, avmWriteData, avmByteEnable);
      end
    end
  end

  always_comb
  begin
    next_readData = 32'h0000_0000;
    if (!avmRead || !cfgAllowed)
    begin
      next_readData = 32'h0000_0000;
    end
    else if (avmAddress < CFG_L1D_BASE)
    begin
      next_readData = l1pPerm[avmAddress[5:2]];
    end
    else if (avmAddress < CFG_L2_BASE)
    begin
      next_readData = l1dPerm[avmAddress[5:2]];
    end
    else if (avmAddress < CFG_LOCAL_CTRL)
    begin
      next_readData = l2Perm[6'(avmAddress[11:2] - 10'(CFG_L2_BASE >> 2))];
    end
    else if (avmAddress == CFG_LOCAL_CTRL)
    begin
      next_readData = localCtrl;
    end
    else if (avmAddress == CFG_FAULT_ADDR)
    begin
      next_readData = faultAddr;
    end
    else if (avmAddress == CFG_FAULT_INFO)
    begin
      next_readData = faultInfo;
    end
  end

  // read data captured in the wait cycle, stands while waitrequest is low
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      avmReadData <= 32'h0000_0000;
    end
    else if (avmRead && !avmDone)
    begin
      avmReadData <= next_readData;
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  mmp_mem_t mem;
  logic isLocal;
  logic [1:0] tgtCore;
  logic [31:0] off;
  logic [31:0] gOff;
  logic [31:0] perm;
  logic ok;

  always_comb
  begin
    mem = MMP_NONE;
    isLocal = 1'b0;
    tgtCore = 2'd0;
    off = 32'h0;
    gOff = req.addr - GLOBAL_BASE;
    // local window serves only the issuing core itself
    if (req.isCore && req.addr >= LOCAL_L2_BASE &&
        req.addr < LOCAL_L2_BASE + L2_SPAN) // R01
    begin
      mem = MMP_L2;
      isLocal = 1'b1;
      tgtCore = req.coreNum;
      off = req.addr - LOCAL_L2_BASE;
    end
    else if (req.isCore && req.addr >= LOCAL_L1P_BASE &&
             req.addr < LOCAL_L1P_BASE + L1_SPAN) // R01
    begin
      mem = MMP_L1P;
      isLocal = 1'b1;
      tgtCore = req.coreNum;
      off = req.addr - LOCAL_L1P_BASE;
    end
    else if (req.isCore && req.addr >= LOCAL_L1D_BASE &&
             req.addr < LOCAL_L1D_BASE + L1_SPAN) // R01
    begin
      mem = MMP_L1D;
      isLocal = 1'b1;
      tgtCore = req.coreNum;
      off = req.addr - LOCAL_L1D_BASE;
    end
    else if (req.addr >= GLOBAL_BASE &&
             gOff < GLOBAL_STRIDE * NUM_CORES) // R01 R02
    begin
      tgtCore = 2'(gOff / GLOBAL_STRIDE);
      off = gOff % GLOBAL_STRIDE;
      if (off >= LOCAL_L2_BASE && off < LOCAL_L2_BASE + L2_SPAN)
      begin
        mem = MMP_L2;
        off = off - LOCAL_L2_BASE;
      end
      else if (off >= LOCAL_L1P_BASE && off < LOCAL_L1P_BASE + L1_SPAN)
      begin
        mem = MMP_L1P;
        off = off - LOCAL_L1P_BASE;
      end
      else if (off >= LOCAL_L1D_BASE && off < LOCAL_L1D_BASE + L1_SPAN)
      begin
        mem = MMP_L1D;
        off = off - LOCAL_L1D_BASE;
      end
    end
  end

  // page select and check
  always_comb
  begin
    case (mem)
      MMP_L1P: perm = l1pPerm[off[L1_PAGE_SHIFT +: 4]]; // R06 R08
      MMP_L1D: perm = l1dPerm[off[L1_PAGE_SHIFT +: 4]]; // R06 R08
      MMP_L2: perm = l2Perm[off[L2_PAGE_SHIFT +: 6]]; // R07 R08
      default: perm = 32'h0;
    endcase
    // dma requests arrive with the programming core id already set
    ok = (mem != MMP_NONE) &&
         perm_ok(perm, req.kind, req.supervisor, req.reqId,
                 isLocal); // R04 R11
  end

  // ---------------------------------------------------------------
  // outcome registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      grant <= '0;
      denyValid <= 1'b0;
      exception <= 1'b0;
    end
    else
    begin
      grant.valid <= req.valid && ok; // R15
      grant.allowed <= ok;
      grant.write <= req.kind == MMP_WRITE;
      grant.mem <= mem;
      grant.targetCore <= tgtCore;
      grant.offset <= off[20:0];
      grant.wdata <= req.wdata;
      denyValid <= req.valid && !ok; // R15
      exception <= req.valid && !ok && localCtrl[0]; // R13
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      faultAddr <= 32'h0;
      faultInfo <= 32'h0;
    end
    else if (req.valid && !ok)
    begin
      faultAddr <= req.addr;
      faultInfo <= {25'h0, req.supervisor, 2'(req.kind), req.reqId};
    end
  end

  a_deny_exc: assert property (@(posedge clock) disable iff (reset) // R13
    (req.valid && !ok && localCtrl[0]) |=> exception)
    else $error("violation without exception");
  a_deny_nogrant: assert property (@(posedge clock) disable iff (reset) // R15
    denyValid |-> !grant.valid)
    else $error("denied access granted");
  a_local_own: assert property (@(posedge clock) disable iff (reset) // R01
    (req.valid && isLocal) |-> (req.isCore && tgtCore == req.coreNum))
    else $error("local alias reached another core");
  a_user_cfg: assert property (@(posedge clock) disable iff (reset) // R10
    (avmWrite && !avmSupervisor) |=> $stable(localCtrl))
    else $error("user changed configuration");
  a_local_gate: assert property (@(posedge clock) disable iff (reset) // R05
    (req.valid && isLocal && !perm[PERM_LOCAL]) |=> denyValid)
    else $error("blocked local access not denied");
  a_id_gate: assert property (@(posedge clock) disable iff (reset) // R03
    (req.valid && !isLocal && mem != MMP_NONE &&
     !perm[PERM_ID_LSB + 32'(req.reqId)]) |=> denyValid)
    else $error("foreign requestor not denied");
  a_write_gate: assert property (@(posedge clock) disable iff (reset) // R12
    (req.valid && req.kind == MMP_WRITE &&
     !(req.supervisor ? perm[PERM_SW] : perm[PERM_UW])) |=> denyValid)
    else $error("write without permission not denied");
endmodule

//--- mmp_master_model.sv
// model of the bus masters that feed the access checker
`timescale 1ns/1ns
module mmp_master_model
  import mmp_pkg::*;
(
  input wire logic go,
  input wire logic [31:0] addr,
  input mmp_pkg::mmp_kind_t kind,
  input wire logic [1:0] core,
  input wire logic dma,
  input wire logic sup,
  input wire logic [31:0] wdata,
  output mmp_pkg::mmp_req_t req
);
  // --------------------------------------------
  // request build
  // --------------------------------------------
  always_comb
  begin
    req.valid = go;
    // released lines show inverted values, not the last ones
    req.addr = go ? addr : ~addr;
    req.wdata = go ? wdata : ~wdata;
    req.kind = kind;
    // dma carries the id of the core that programmed it
    req.reqId = ID_W'(core);
    req.isCore = !dma;
    req.coreNum = core;
    req.supervisor = sup;
  end
endmodule

//--- mmp_pkg.sv
// package for the multicore memory protection checker
package mmp_pkg;
  localparam int NUM_CORES = 3;
  localparam int ID_W = 4;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  // memory sizes and page counts
  localparam int L1_PAGES = 16;
  localparam int L1_PAGE_BYTES = 2048;
  localparam int L2_PAGES = 64;
  localparam int L2_PAGE_BYTES = 32768;
  localparam int L1_PAGE_SHIFT = 11;
  localparam int L2_PAGE_SHIFT = 15;
  // local map: core sees own memories here
  localparam logic [31:0] LOCAL_L1P_BASE = 32'h00e0_0000;
  localparam logic [31:0] LOCAL_L1D_BASE = 32'h00f0_0000;
  localparam logic [31:0] LOCAL_L2_BASE = 32'h0080_0000;
  // global map: core n memories at GLOBAL_BASE + n*GLOBAL_STRIDE + local
  localparam logic [31:0] GLOBAL_BASE = 32'h1000_0000;
  localparam logic [31:0] GLOBAL_STRIDE = 32'h0100_0000;
  localparam logic [31:0] L1_SPAN = 32'h0000_8000;
  localparam logic [31:0] L2_SPAN = 32'h0020_0000;
  // protection configuration window on the register bus
  localparam logic [11:0] CFG_L1P_BASE = 12'h000;
  localparam logic [11:0] CFG_L1D_BASE = 12'h040;
  localparam logic [11:0] CFG_L2_BASE = 12'h080;
  localparam logic [11:0] CFG_LOCAL_CTRL = 12'h180;
  localparam logic [11:0] CFG_FAULT_ADDR = 12'h184;
  localparam logic [11:0] CFG_FAULT_INFO = 12'h188;
  // permission word field positions
  localparam int PERM_UR = 0;
  localparam int PERM_UW = 1;
  localparam int PERM_UX = 2;
  localparam int PERM_SR = 3;
  localparam int PERM_SW = 4;
  localparam int PERM_SX = 5;
  localparam int PERM_LOCAL = 6;
  localparam int PERM_ID_LSB = 8;
  localparam logic [31:0] PERM_RESET = 32'h0000_ff7f;
  localparam logic [31:0] LOCAL_CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] CFG_WINDOW_BASE = 32'h0184_a000;
  localparam logic [31:0] CFG_WINDOW_SPAN = 32'h0000_1000;

  typedef enum logic [1:0] {MMP_READ, MMP_WRITE, MMP_FETCH} mmp_kind_t;
  typedef enum logic [1:0] {MMP_L1P, MMP_L1D, MMP_L2, MMP_NONE} mmp_mem_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    mmp_kind_t kind;
    logic [ID_W-1:0] reqId;
    logic isCore;
    logic [1:0] coreNum;
    logic supervisor;
    logic [DATA_W-1:0] wdata;
  } mmp_req_t;

  typedef struct packed {
    logic valid;
    logic allowed;
    logic write;
    mmp_mem_t mem;
    logic [1:0] targetCore;
    logic [20:0] offset;
    logic [DATA_W-1:0] wdata;
  } mmp_grant_t;
endpackage

//--- tb.sv
// self-checking testbench for the memory protection checker
`timescale 1ns/1ns
module tb;
  import mmp_pkg::*;
  logic clock, reset, go, dma, sup, denyValid, exception;
  logic [1:0] core;
  logic [31:0] addr, rdv;
  int cyc;
  mmp_kind_t kind;
  mmp_req_t req;
  mmp_grant_t grant;
  logic [11:0] avmAddress;
  logic avmRead, avmWrite, avmSupervisor, avmWaitRequest;
  logic [31:0] avmWriteData, avmReadData;
  logic [ID_W-1:0] avmReqId;
  int num_errors, n_checks;
  localparam logic [31:0] G0L2 = GLOBAL_BASE + LOCAL_L2_BASE;

  mmp_master_model i_master (.go(go), .addr(addr), .kind(kind),
    .core(core), .dma(dma), .sup(sup), .wdata(32'h5a5a_0001), .req(req));
  mmp_checker i_dut (.clock(clock), .reset(reset), .req(req),
    .grant(grant), .denyValid(denyValid), .exception(exception),
    .avmAddress(avmAddress), .avmRead(avmRead), .avmWrite(avmWrite),
    .avmWriteData(avmWriteData), .avmByteEnable(4'hf),
    .avmReqId(avmReqId), .avmSupervisor(avmSupervisor),
    .avmReadData(avmReadData), .avmWaitRequest(avmWaitRequest));

  // --------------------------------------------
  // helpers
  // --------------------------------------------
  task automatic close_out;
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic av(input logic w, input logic s, input logic [ID_W-1:0] id,
                    input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    avmWrite <= w;
    avmRead <= !w;
    avmSupervisor <= s;
    avmReqId <= id;
    avmAddress <= a;
    avmWriteData <= d;
    @(posedge clock);
    while (avmWaitRequest !== 1'b0)
      @(posedge clock);
    rdv = avmReadData;
    avmRead <= 1'b0;
    avmWrite <= 1'b0;
  endtask

  task automatic acc(input logic [1:0] c, input logic d, input logic s,
                     input mmp_kind_t k, input logic [31:0] a,
                     input logic ea, input logic ee);
    @(posedge clock);
    core <= c;
    dma <= d;
    sup <= s;
    kind <= k;
    addr <= a;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    #1;
    chk(grant.valid, ea);
    chk(denyValid, !ea);
    chk(exception, ee);
  endtask

  // --------------------------------------------
  // clock, reset and watchdog
  // --------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      close_out;
    end
  end

  initial
  begin
    {go, dma, sup, core, addr} = '0;
    kind = MMP_READ;
    {avmAddress, avmRead, avmWrite, avmSupervisor, avmWriteData} = '0;
    avmReqId = '0;
    reset = 1'b1;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk(exception, 1'b0);
    av(0, 1, 0, CFG_L1P_BASE, 0);
    chk(rdv, PERM_RESET);
    av(0, 1, 0, CFG_LOCAL_CTRL, 0);
    chk(rdv, LOCAL_CTRL_RESET);
    av(0, 1, 0, 12'h1fc, 0);
    chk(rdv, 32'h0);
    av(1, 1, 0, 12'h084, 32'h0000_0208);
    av(1, 0, 0, 12'h084, 32'h0000_ffff);
    av(1, 1, 4'h5, 12'h084, 32'h0000_ffff);
    av(0, 1, 0, 12'h084, 0);
    chk(rdv, 32'h0000_0208);
    acc(1, 0, 1, MMP_READ, G0L2 + 32'h8004, 1, 0);
    chk(grant.mem, MMP_L2);
    chk(grant.targetCore, 2'h0);
    chk(grant.offset, 16'h8004);
    acc(1, 0, 0, MMP_READ, G0L2 + 32'h8004, 0, 1);
    acc(1, 0, 1, MMP_WRITE, G0L2 + 32'h8004, 0, 1);
    acc(2, 0, 1, MMP_READ, G0L2 + 32'h8004, 0, 1);
    acc(2, 0, 1, MMP_READ, G0L2 + 32'hfffc, 0, 1);
    acc(1, 1, 1, MMP_READ, G0L2 + 32'hfffc, 1, 0);
    acc(2, 0, 0, MMP_READ, G0L2 + 32'h10000, 1, 0);
    acc(0, 0, 0, MMP_READ, G0L2 + 32'h7ffc, 1, 0);
    av(1, 1, 0, CFG_L1D_BASE, 32'h0000_ff3f);
    acc(0, 0, 1, MMP_READ, LOCAL_L1D_BASE, 0, 1);
    acc(0, 0, 1, MMP_READ, GLOBAL_BASE + LOCAL_L1D_BASE, 1, 0);
    acc(0, 0, 1, MMP_READ, LOCAL_L1D_BASE + 32'h800, 1, 0);
    chk(grant.offset, 16'h0800);
    av(1, 1, 0, 12'h03c, 32'h0000_ff44);
    acc(0, 0, 0, MMP_FETCH, LOCAL_L1P_BASE + 32'h7800, 1, 0);
    chk(grant.mem, MMP_L1P);
    acc(0, 0, 0, MMP_READ, LOCAL_L1P_BASE + 32'h7800, 0, 1);
    acc(0, 0, 0, MMP_WRITE, LOCAL_L1P_BASE + 32'h77fc, 1, 0);
    chk(grant.write, 1'b1);
    chk(grant.wdata, 32'h5a5a_0001);
    av(1, 1, 0, CFG_LOCAL_CTRL, 32'h0);
    acc(0, 0, 0, MMP_READ, LOCAL_L1P_BASE + 32'h7800, 0, 0);
    av(0, 1, 0, CFG_FAULT_ADDR, 0);
    chk(rdv, LOCAL_L1P_BASE + 32'h7800);
    close_out;
  end
endmodule
